// [dv/aae_axis_logic_tb_top.sv]
// Purpose: Self-checking bench for one axis of amp-enable and encoder logic
// Assumes: Default parameters, amp enable active high
// Notes:   Expected positions are tracked in the bench, never read back

`timescale 1ns/1ns
module aae_axis_logic_tb_top;
  import aae_pkg::*;

  logic core_clk, nrst, quadChanAIn, quadChanANIn, quadChanBIn, quadChanBNIn;
  logic indexPulseIn, indexPulseNIn, diffMode, pulseDirMode, countInvert;
  logic motorTypeInvert, shutoffOnFault, driveEnableCmd, driveDisableCmd;
  logic watchdogTrip, torqueLimitLoad, ampEnableOut, indexSeen, faultActive, cmplFlip;
  logic [31:0] faultThreshold, commandedPos, tellPosition, indexPosition, positionError;
  logic [15:0] torqueLimitValue, filterCommand, analogCommandOut, torqueLimit;
  int nErrors, checksDone, expPos;

  aae_axis_logic u_aae_axis_logic (.core_clk, .nrst, .quadChanAIn, .quadChanANIn, .quadChanBIn,
    .quadChanBNIn, .indexPulseIn, .indexPulseNIn, .diffMode, .pulseDirMode, .countInvert,
    .motorTypeInvert, .shutoffOnFault, .driveEnableCmd, .driveDisableCmd, .watchdogTrip,
    .faultThreshold, .torqueLimitLoad, .torqueLimitValue, .commandedPos, .filterCommand,
    .ampEnableOut, .analogCommandOut, .torqueLimit, .tellPosition, .indexPosition,
    .indexSeen, .positionError, .faultActive);

  aae_encoder_model u_aae_encoder_model (.core_clk(core_clk), .cmplFlip(cmplFlip), .chanA(quadChanAIn),
    .chanAN(quadChanANIn), .chanB(quadChanBIn), .chanBN(quadChanBNIn),
    .indexP(indexPulseIn), .indexN(indexPulseNIn));

  // 25 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Codes for the command line that strobe raises
  localparam int STB_EN   = 0;
  localparam int STB_OFF  = 1;
  localparam int STB_WDOG = 2;
  localparam int STB_TL   = 3;

  // One-cycle strobe; all four command lines drop together after it
  task automatic strobe(input int which);
    case (which)
      STB_EN:   driveEnableCmd  = 1'b1;
      STB_OFF:  driveDisableCmd = 1'b1;
      STB_WDOG: watchdogTrip    = 1'b1;
      default:  torqueLimitLoad = 1'b1;
    endcase
    tick(1);
    {driveEnableCmd, driveDisableCmd, watchdogTrip, torqueLimitLoad} = 4'h0;
    tick(2);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {nrst, diffMode, pulseDirMode, countInvert, motorTypeInvert} = 5'h0;
    {shutoffOnFault, driveEnableCmd, driveDisableCmd, watchdogTrip, torqueLimitLoad} = 5'h0;
    faultThreshold   = 32'hFFFF_FFFF;
    commandedPos     = 32'h0000_0000;
    torqueLimitValue = 16'h0000;
    filterCommand    = 16'h0000;
    cmplFlip         = 1'b0;
    nErrors = 0;
    checksDone = 0;
    expPos = 0;
    tick(3);
    nrst = 1'b1;
    tick(2);
    chk("ampEnableOut", 32'h0, ampEnableOut);
    chk("torqueLimit", 32'h0000_2706, torqueLimit);
    chk("tellPosition", 32'h0, tellPosition);
    $display("test reset done");

    // Quadrature both ways, dead channel, inverted count, differential
    for (int i = 0; i < 8; i++) u_aae_encoder_model.quadStep(1'b1);
    chk("tellPosition", 32'd8, tellPosition);
    for (int i = 0; i < 3; i++) u_aae_encoder_model.quadStep(1'b0);
    chk("tellPosition", 32'd5, tellPosition);
    for (int i = 0; i < 3; i++) u_aae_encoder_model.quadStep(1'b1);
    for (int i = 0; i < 3; i++)
    begin
      u_aae_encoder_model.setA(1'b1);
      chk("tellPosition", 32'd7, tellPosition);
      u_aae_encoder_model.setA(1'b0);
      chk("tellPosition", 32'd8, tellPosition);
    end
    countInvert = 1'b1;
    for (int i = 0; i < 4; i++) u_aae_encoder_model.quadStep(1'b1);
    chk("tellPosition", 32'd4, tellPosition);
    countInvert = 1'b0;
    diffMode = 1'b1;
    for (int i = 0; i < 2; i++) u_aae_encoder_model.quadStep(1'b1);
    chk("tellPosition", 32'd6, tellPosition);
    u_aae_encoder_model.indexStrobe();
    chk("indexSeen", 32'h1, indexSeen);
    chk("indexPosition", 32'd6, indexPosition);
    // Complements copying the true lines must read idle; steps back to phase zero unseen
    cmplFlip = 1'b1;
    tick(4);
    for (int i = 0; i < 2; i++) u_aae_encoder_model.quadStep(1'b0);
    chk("tellPosition", 32'd6, tellPosition);
    cmplFlip = 1'b0;
    tick(4);
    chk("tellPosition", 32'd6, tellPosition);
    $display("test quadrature done");

    // Pulse and direction, then one pulse with the count inverted
    pulseDirMode = 1'b1;
    for (int i = 0; i < 3; i++) u_aae_encoder_model.pulseStep(1'b1);
    chk("tellPosition", 32'd9, tellPosition);
    countInvert = 1'b1;
    u_aae_encoder_model.pulseStep(1'b1);
    chk("tellPosition", 32'd8, tellPosition);
    countInvert = 1'b0;
    for (int i = 0; i < 2; i++) u_aae_encoder_model.pulseStep(1'b0);
    expPos = 6;
    chk("tellPosition", 32'(expPos), tellPosition);
    $display("test pulse direction done");

    // Enable, torque clamp and loop polarity
    chk("positionError", 32'(-expPos), positionError);
    strobe(STB_EN);
    chk("ampEnableOut", 32'h1, ampEnableOut);
    filterCommand = 16'h2EE0;
    tick(2);
    chk("analogCommandOut", 32'h0000_2706, 32'(analogCommandOut));
    torqueLimitValue = 16'h03E8;
    strobe(STB_TL);
    filterCommand = 16'hEC78;
    tick(2);
    chk("analogCommandOut", 32'h0000_FC18, 32'(analogCommandOut));
    motorTypeInvert = 1'b1;
    filterCommand = 16'h01F4;
    tick(2);
    chk("analogCommandOut", 32'h0000_FE0C, 32'(analogCommandOut));
    motorTypeInvert = 1'b0;
    $display("test torque done");

    // Error limit at and just past the threshold, then recovery
    shutoffOnFault = 1'b1;
    faultThreshold = 32'h0000_07D0;
    commandedPos = 32'(expPos + 2000);
    tick(5);
    chk("ampEnableOut", 32'h1, ampEnableOut);
    chk("positionError", 32'h0000_07D0, positionError);
    commandedPos = 32'(expPos + 2001);
    tick(5);
    chk("ampEnableOut", 32'h0, ampEnableOut);
    chk("faultActive", 32'h1, faultActive);
    strobe(STB_EN);
    chk("ampEnableOut", 32'h0, ampEnableOut);
    commandedPos = 32'(expPos);
    tick(3);
    strobe(STB_EN);
    chk("ampEnableOut", 32'h1, ampEnableOut);
    chk("faultActive", 32'h0, faultActive);

    // Disable wins over a same-cycle enable; watchdog drops the amp
    driveEnableCmd = 1'b1;
    strobe(STB_OFF);
    chk("ampEnableOut", 32'h0, ampEnableOut);
    chk("analogCommandOut", 32'h0, 32'(analogCommandOut));
    strobe(STB_EN);
    chk("ampEnableOut", 32'h1, ampEnableOut);
    strobe(STB_WDOG);
    chk("ampEnableOut", 32'h0, ampEnableOut);
    chk("faultActive", 32'h0, faultActive);
    $display("test amp enable done");

    // Mid-run reset brings back the reset values, the torque default too; error then reads commanded minus the zeroed count
    nrst = 1'b0;
    tick(3);
    nrst = 1'b1;
    tick(2);
    chk("torqueLimit", 32'h0000_2706, torqueLimit);
    chk("indexSeen", 32'h0, indexSeen);
    chk("tellPosition", 32'h0, tellPosition);
    chk("positionError", 32'(expPos), positionError);
    chk("faultActive", 32'h0, faultActive);
    chk("ampEnableOut", 32'h0, ampEnableOut);
    $display("test mid-run reset done");
    results();
  end
endmodule  // aae_axis_logic_tb_top

// [dv/aae_encoder_model.sv]
// Purpose: Encoder model for one axis, true and complement pins
// Assumes: Callers space steps so pins sit stable for four cycles
// Notes:   Pins change 1 ns after the rising edge of core_clk

`timescale 1ns/1ns
module aae_encoder_model
(
  input  wire logic core_clk,
  input  wire logic cmplFlip,
  output logic      chanA,
  output logic      chanAN,
  output logic      chanB,
  output logic      chanBN,
  output logic      indexP,
  output logic      indexN
);
  logic [1:0] phase;

  // Complements mirror the true lines; cmplFlip makes them copy them, a wiring fault
  assign chanAN = ~chanA ^ cmplFlip;
  assign chanBN = ~chanB ^ cmplFlip;
  assign indexN = ~indexP ^ cmplFlip;

  // Idle: all true lines low until a step is asked for
  initial
  begin
    phase  = 2'h0;
    chanA  = 1'b0;
    chanB  = 1'b0;
    indexP = 1'b0;
  end

  // Hold pins four cycles, beyond the synchroniser's two stages
  task automatic hold();
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // Gray step: forward order of (A,B) is 00, 01, 11, 10
  task automatic quadStep(input logic up);
    phase = up ? phase + 2'h1 : phase - 2'h1;
    chanA = phase[1];
    chanB = phase[1] ^ phase[0];
    hold();
  endtask

  // Dead channel B: only A moves
  task automatic setA(input logic v);
    chanA = v;
    hold();
  endtask

  // Direction on B first, then one pulse on A
  task automatic pulseStep(input logic up);
    chanB = up;
    hold();
    chanA = 1'b1;
    hold();
    chanA = 1'b0;
    hold();
  endtask

  task automatic indexStrobe();
    indexP = 1'b1;
    hold();
    indexP = 1'b0;
    hold();
  endtask
endmodule  // aae_encoder_model

// [verilog/aae_axis_logic.sv]
// Purpose: One axis: encoder count, position error, amp enable, torque clamp
// Assumes: Commands and settings come from logic on core_clk
// Notes:   Analog values are signed millivolts; DAC sits outside
//
// Behaviour
// - Amp drops on watchdog, disable, or fault
// - Amp enable high means amplifier enabled, low when AMP_ACTIVE_LOW is set
// - A, B, index, single-ended or differential
// - Pulse on A, direction on B counts
// - Count all edges; dead channel only dithers
// - Error limit in counts trips amp shutoff
// - Analog output clamped to torque limit
// - Torque limit resets to 9.99 volts
// - Loop and count direction invertible by settings
// - Error is commanded minus actual, readable

`timescale 1ns/1ns
module aae_axis_logic
  import aae_pkg::*;
#(
  parameter int   POS_W          = AAE_POS_W,
  parameter logic AMP_ACTIVE_LOW = 1'b0
)
(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 quadChanAIn,
  input  wire logic                 quadChanANIn,
  input  wire logic                 quadChanBIn,
  input  wire logic                 quadChanBNIn,
  input  wire logic                 indexPulseIn,
  input  wire logic                 indexPulseNIn,
  input  wire logic                 diffMode,
  input  wire logic                 pulseDirMode,
  input  wire logic                 countInvert,
  input  wire logic                 motorTypeInvert,
  input  wire logic                 shutoffOnFault,
  input  wire logic                 driveEnableCmd,
  input  wire logic                 driveDisableCmd,
  input  wire logic                 watchdogTrip,
  input  wire logic [POS_W-1:0]     faultThreshold,
  input  wire logic                 torqueLimitLoad,
  input  wire logic [15:0]          torqueLimitValue,
  input  wire logic [POS_W-1:0]     commandedPos,
  input  wire logic [AAE_CMD_W-1:0] filterCommand,
  output logic                      ampEnableOut,
  output logic      [AAE_CMD_W-1:0] analogCommandOut,
  output logic      [15:0]          torqueLimit,
  output logic      [POS_W-1:0]     tellPosition,
  output logic      [POS_W-1:0]     indexPosition,
  output logic                      indexSeen,
  output logic      [POS_W-1:0]     positionError,
  output logic                      faultActive
);

  aae_amp_type           ampStateReg;
  aae_amp_type           ampStateNext;
  logic [POS_W-1:0]      errMag;
  logic                  overLimitReg;
  logic signed [AAE_CMD_W:0] cmdWide;
  logic signed [AAE_CMD_W:0] tlPos;
  logic signed [AAE_CMD_W:0] clampNext;

  // ----------------------------------------------------------------
  // Encoder front end
  // ----------------------------------------------------------------
  aae_encoder #(
    .POS_W (POS_W)
  ) uEncoder (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .pinVec        ({indexPulseNIn, indexPulseIn, quadChanBNIn, quadChanBIn, quadChanANIn, quadChanAIn}),
    .diffMode      (diffMode),
    .pulseDirMode  (pulseDirMode),
    .countInvert   (countInvert),
    .tellPosition  (tellPosition),
    .indexPosition (indexPosition),
    .indexSeen     (indexSeen)
  );

  // ----------------------------------------------------------------
  // Position error and limit compare
  // ----------------------------------------------------------------

  // Error register; the most negative value reads as huge, fail-safe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      positionError <= AAE_POS_RESET[POS_W-1:0];
    else
      positionError <= commandedPos - tellPosition;
  end

  assign errMag = positionError[POS_W-1] ? (~positionError + 1'b1) : positionError;

  // Compare registered to keep the subtract and compare paths apart
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      overLimitReg <= 1'b0;
    else
      overLimitReg <= (errMag > faultThreshold);
  end

  // ----------------------------------------------------------------
  // Amplifier enable state
  // ----------------------------------------------------------------

  // Disable and watchdog override every state, including enable requests
  always_comb
  begin
    ampStateNext = ampStateReg;
    unique case (ampStateReg)
      AAE_AMP_OFF,
      AAE_AMP_TRIP:
        if (driveEnableCmd && !(overLimitReg && shutoffOnFault))
          ampStateNext = AAE_AMP_ON;
      AAE_AMP_ON:
        if (overLimitReg && shutoffOnFault)
          ampStateNext = AAE_AMP_TRIP;
      default:
        ampStateNext = AAE_AMP_OFF;
    endcase
    if (driveDisableCmd || watchdogTrip)
      ampStateNext = AAE_AMP_OFF;
  end

  // State and its output flops update on the same edge
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ampStateReg  <= AAE_AMP_OFF;
      ampEnableOut <= AMP_ACTIVE_LOW;
      faultActive  <= 1'b0;
    end
    else
    begin
      ampStateReg  <= ampStateNext;
      ampEnableOut <= (ampStateNext == AAE_AMP_ON) ^ AMP_ACTIVE_LOW;
      faultActive  <= (ampStateNext == AAE_AMP_TRIP);
    end
  end

  // ----------------------------------------------------------------
  // Torque limit and analog command
  // ----------------------------------------------------------------

  // Loads above full scale saturate; clamp would otherwise be dead
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      torqueLimit <= AAE_TL_DEFAULT_MV;
    else if (torqueLimitLoad)
      torqueLimit <= (torqueLimitValue > AAE_FULL_SCALE_MV) ? AAE_FULL_SCALE_MV : torqueLimitValue;
  end

  // One extra bit so negating the most negative input cannot wrap
  always_comb
  begin
    cmdWide = $signed({filterCommand[AAE_CMD_W-1], filterCommand});
    if (motorTypeInvert)
      cmdWide = -cmdWide;
    tlPos = $signed({1'b0, torqueLimit});
    if (cmdWide > tlPos)
      clampNext = tlPos;
    else if (cmdWide < -tlPos)
      clampNext = -tlPos;
    else
      clampNext = cmdWide;
  end

  // Output held at zero volts while the registered state is not on, one cycle behind amp enable
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      analogCommandOut <= '0;
    else if (ampStateReg != AAE_AMP_ON)
      analogCommandOut <= '0;
    else
      analogCommandOut <= clampNext[AAE_CMD_W-1:0];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  amp_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (driveDisableCmd || watchdogTrip) |=> (ampEnableOut == AMP_ACTIVE_LOW) && !faultActive)
    else $error("amp stayed on after disable or watchdog");

  amp_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ampStateReg == AAE_AMP_ON) == (ampEnableOut != AMP_ACTIVE_LOW))
    else $error("amp enable level disagrees with state");

  fault_trip_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ((errMag > faultThreshold) && shutoffOnFault && ampStateReg == AAE_AMP_ON) ##1
      (shutoffOnFault && ampStateReg == AAE_AMP_ON && !driveDisableCmd && !watchdogTrip)
      |=> faultActive && (ampEnableOut == AMP_ACTIVE_LOW))
    else $error("over-limit error did not trip amp");

  clamp_range_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> ($signed({analogCommandOut[AAE_CMD_W-1], analogCommandOut}) <=
      $signed({1'b0, $past(torqueLimit)})) &&
      ($signed({analogCommandOut[AAE_CMD_W-1], analogCommandOut}) >= -$signed({1'b0, $past(torqueLimit)})))
    else $error("analog command beyond torque limit");

  tl_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !$past(nrst) |-> (torqueLimit == AAE_TL_DEFAULT_MV))
    else $error("torque limit not at default after reset");

  loop_sign_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ampStateReg == AAE_AMP_ON && !filterCommand[AAE_CMD_W-1])
      |=> ($past(motorTypeInvert) ? ($signed(analogCommandOut) <= 0) : ($signed(analogCommandOut) >= 0)))
    else $error("loop polarity setting not applied");

  err_value_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> (positionError == $past(commandedPos) - $past(tellPosition)))
    else $error("position error not commanded minus actual");

  cov_trip_c: cover property (@(posedge core_clk) disable iff (!nrst)
    (ampStateReg == AAE_AMP_ON) ##1 (ampStateReg == AAE_AMP_TRIP));

  cov_clamp_c: cover property (@(posedge core_clk) disable iff (!nrst)
    (ampStateReg == AAE_AMP_ON) && (clampNext != cmdWide));

  cov_index_c: cover property (@(posedge core_clk) disable iff (!nrst)
    $rose(indexSeen));

  cov_pulse_c: cover property (@(posedge core_clk) disable iff (!nrst)
    pulseDirMode && (tellPosition != $past(tellPosition)));

endmodule // aae_axis_logic

// [verilog/aae_encoder.sv]
// Purpose: Encoder pin synchroniser, quadrature or pulse/direction counter
// Assumes: Pins are asynchronous to core_clk
// Notes:   Counts every edge of A and B in quadrature mode; index edge latches the position

`timescale 1ns/1ns
module aae_encoder
  import aae_pkg::*;
#(
  parameter int POS_W = AAE_POS_W
)
(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic [AAE_PIN_N-1:0] pinVec,
  input  wire logic                 diffMode,
  input  wire logic                 pulseDirMode,
  input  wire logic                 countInvert,
  output logic      [POS_W-1:0]     tellPosition,
  output logic      [POS_W-1:0]     indexPosition,
  output logic                      indexSeen
);

  logic [AAE_PIN_N-1:0] sync1Reg;
  logic [AAE_PIN_N-1:0] sync2Reg;
  logic                 aNow;
  logic                 bNow;
  logic                 iNow;
  logic                 aPrevReg;
  logic                 bPrevReg;
  logic                 iPrevReg;
  logic                 primedReg;
  logic                 stepHit;
  logic                 stepUp;

  // ----------------------------------------------------------------
  // Two-stage synchronisers, one pair per pin
  // ----------------------------------------------------------------
  // Not reset: stages keep following the pins, so counting starts from the real level
  genvar g;
  generate
    for (g = 0; g < AAE_PIN_N; g++)
    begin : gSync
      always_ff @(posedge core_clk)
      begin
        sync1Reg[g] <= pinVec[g];
        sync2Reg[g] <= sync1Reg[g];
      end
    end
  endgenerate

  // Differential pins read high only when true is high and complement low
  assign aNow = diffMode ? (sync2Reg[AAE_PIN_A] & ~sync2Reg[AAE_PIN_AN]) : sync2Reg[AAE_PIN_A];
  assign bNow = diffMode ? (sync2Reg[AAE_PIN_B] & ~sync2Reg[AAE_PIN_BN]) : sync2Reg[AAE_PIN_B];
  assign iNow = diffMode ? (sync2Reg[AAE_PIN_I] & ~sync2Reg[AAE_PIN_IN]) : sync2Reg[AAE_PIN_I];

  // Step decode; a double change is a lost edge and is dropped
  always_comb
  begin
    if (pulseDirMode)
    begin
      stepHit = aNow & ~aPrevReg;
      stepUp  = bNow ^ countInvert;
    end
    else
    begin
      stepHit = (aNow ^ aPrevReg) ^ (bNow ^ bPrevReg);
      stepUp  = (aPrevReg ^ bNow) ^ countInvert;
    end
  end

  // Previous levels track the pins through reset; a pin resting high gives no false edge
  always_ff @(posedge core_clk)
  begin
    aPrevReg <= aNow;
    bPrevReg <= bNow;
    iPrevReg <= iNow;
  end

  // Primed blocks the first edge; a power-up reset under two edges is not enough
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      primedReg <= 1'b0;
    else
      primedReg <= 1'b1;
  end

  // Position counter and index capture
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tellPosition  <= AAE_POS_RESET[POS_W-1:0];
      indexPosition <= AAE_POS_RESET[POS_W-1:0];
      indexSeen     <= 1'b0;
    end
    else
    begin
      if (primedReg && stepHit)
        tellPosition <= stepUp ? tellPosition + 1'b1 : tellPosition - 1'b1;
      if (primedReg && iNow && !iPrevReg)
      begin
        indexPosition <= tellPosition;
        indexSeen     <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sync_depth_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(nrst) && $past(nrst, 2)) |-> (sync2Reg == $past(pinVec, 2)))
    else $error("synchroniser depth wrong");

  diff_reject_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (diffMode && sync2Reg[AAE_PIN_A] && sync2Reg[AAE_PIN_AN]) |-> !aNow)
    else $error("differential A accepted while complement high");

  single_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> ((tellPosition == $past(tellPosition)) ||
      (tellPosition == $past(tellPosition) + 1'b1) || (tellPosition == $past(tellPosition) - 1'b1)))
    else $error("position moved more than one count");

  pulse_up_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (primedReg && pulseDirMode && aNow && !aPrevReg && bNow && !countInvert)
      |=> (tellPosition == $past(tellPosition) + 1'b1))
    else $error("pulse with direction high did not count up");

  invert_dir_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (primedReg && pulseDirMode && aNow && !aPrevReg && bNow && countInvert)
      |=> (tellPosition == $past(tellPosition) - 1'b1))
    else $error("inverted direction did not count down");

endmodule // aae_encoder

// [verilog/aae_pkg.sv]
// Purpose: Shared constants and types for the axis amp-enable and encoder logic
// Assumes: Positions in encoder counts, analog values in signed millivolts
// Notes:   Full scale of the analog command is +/-10 V

package aae_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          AAE_POS_W         = 32;
  localparam int          AAE_CMD_W         = 16;
  localparam int          AAE_PIN_N         = 6;
  localparam logic [15:0] AAE_TL_DEFAULT_MV = 16'h2706;   // 9.99 V
  localparam logic [15:0] AAE_FULL_SCALE_MV = 16'h2710;   // 10.00 V
  localparam logic [31:0] AAE_POS_RESET     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Pin vector positions
  // ----------------------------------------------------------------
  localparam int AAE_PIN_A  = 0;
  localparam int AAE_PIN_AN = 1;
  localparam int AAE_PIN_B  = 2;
  localparam int AAE_PIN_BN = 3;
  localparam int AAE_PIN_I  = 4;
  localparam int AAE_PIN_IN = 5;

  // ----------------------------------------------------------------
  // Amplifier state, Gray along off -> on -> tripped
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    AAE_AMP_OFF  = 2'b00,
    AAE_AMP_ON   = 2'b01,
    AAE_AMP_TRIP = 2'b11
  } aae_amp_type;

endpackage
